/* File: common/tx_fifo_regs.vh */
// Register map, field positions, reset values and timing counts of the transmit FIFO control block
`ifndef TX_FIFO_REGS_VH
`define TX_FIFO_REGS_VH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define TXF_STATUS_ADDR     16'h91A8
`define TXF_CONTROL_ADDR    16'h91AC

// ----------------------------------------
// Storage geometry
// ----------------------------------------
`define TXF_CAPACITY        11'h400
`define TXF_CAPACITY_WORD   32'h00000400

// ----------------------------------------
// Status fields
// ----------------------------------------
`define ST_IP_BIT           31
`define ST_TXW_BIT          30
`define ST_LANES_HI         27
`define ST_LANES_LO         24
`define ST_FAE_BIT          23
`define ST_UF_BIT           21
`define ST_OF_BIT           20
`define ST_FRAME_READY_FLAG_BIT       19
`define ST_FULL_BIT         18
`define ST_ALARM_BIT        17
`define ST_EMPTY_BIT        16

// ----------------------------------------
// Control fields and reset values
// ----------------------------------------
`define CT_TAG_CONTROL_NEXT_BIT         30
`define CT_WFR_BIT          29
`define CT_TIMER_BIT        28
`define CT_FRAME_MODE_ENABLE_BIT        27
`define CT_GR_HI            26
`define CT_GR_LO            24
`define CT_IPM_BIT          23
`define CT_FAEM_BIT         22
`define CT_ONE_BIT          21
`define CT_UFM_BIT          20
`define CT_OFM_BIT          19
`define CT_TXWM_BIT         18
`define CT_COUNT_HI         15
`define CT_COUNT_LO         0
`define CT_GR_RESET         3'h1
`define CT_TXWM_RESET       1'h1

// ----------------------------------------
// Timer mode prescale: cycles per timer unit
// ----------------------------------------
`define TIMER_UNIT_CYCLES   7'h40
`define TIMER_PRE_LAST      6'h3F

`endif

/* File: logic/ethernet_tx_fifo_ctrl.v */
// Transmit FIFO status, control, level flags, frame tagging and service-request timer
//
// Behaviour
// - Pointer write beyond storage range sets illegal-pointer flag; write one clears it.
// - Illegal-pointer flag raises transfer error unless its mask bit is set.
// - Reader stalled for lack of data sets sticky transmit-wait flag; write one clears.
// - Wait mask set keeps wait flag off error outputs; mask resets to one.
// - Frame boundary lanes field is one-hot: 1000 top byte down to 0001 bottom.
// - Frame mode: write overwriting retry-held frame sets sticky accept-error flag.
// - Accept-error mask set blocks the accept-error flag from the error event.
// - Read passing write pointer sets sticky underflow; stalled reader never sets it.
// - Write passing read pointer sets sticky overflow until software writes one.
// - Underflow and overflow masks each block their flag from the error event.
// - Frame mode only: frame-ready set while complete frames held, clears when all read.
// - Full flag set while storage full, clears only after a read.
// - Alarm flag set while stored byte count is at or below the threshold.
// - Alarm request clears when free bytes fall below four times granularity.
// - Empty flag set while storage holds nothing, clears only on a write.
// - Control-tag bit tags the next data write as control, then clears itself.
// - End-of-frame bit tags the next data write as frame end, then clears itself.
// - Timer mode suppresses frame requests, issues one every counter times 64 cycles.
// - Any data register read or write restarts the service-request timer.
// - Frame functions work only while frame mode enable is set.
// - Stored byte count is compared with the ten-bit alarm threshold.
`timescale 1ns/1ps
`include "tx_fifo_regs.vh"

module ethernet_tx_fifo_ctrl (
	// Clock and reset
	input  wire        core_clk,
	input  wire        rst_n,
	// Register port
	input  wire [15:0] reg_addr,
	input  wire [31:0] reg_wdata,
	input  wire        reg_wr,
	input  wire        reg_rd,
	output reg  [31:0] reg_rdata,
	// Data port (writer side)
	input  wire        data_wr,
	input  wire [2:0]  data_wr_bytes,
	input  wire        data_wr_frame,
	input  wire        data_rd,
	input  wire [2:0]  data_rd_bytes,
	output reg         wr_tag_control,
	output reg         wr_tag_eof,
	// Pointer and threshold registers kept outside
	input  wire        ptr_wr,
	input  wire [31:0] ptr_wr_value,
	input  wire [9:0]  alarm_level,
	input  wire        retry_hold,
	// MAC transmit read bus
	input  wire        mac_rd_req,
	input  wire [2:0]  mac_rd_bytes,
	input  wire        mac_rd_frame_end,
	output wire        mac_rd_grant,
	output wire        mac_rd_wait,
	// Service requests and error event
	output reg         alarm_request,
	output reg         frame_request,
	output wire        fifo_error_event,
	output wire        wait_error
);

	// ----------------------------------------
	// Sticky flag indices
	// ----------------------------------------
	localparam FL_OF  = 0;
	localparam FL_UF  = 1;
	localparam FL_FAE = 2;
	localparam FL_TXW = 3;
	localparam FL_IP  = 4;

	// ----------------------------------------
	// Timer states
	// ----------------------------------------
	localparam TM_IDLE = 2'b01;
	localparam TM_RUN  = 2'b10;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Last byte of an MSB-aligned write of n bytes sits in this lane
	function [3:0] lane_of;
		input [2:0] n;
		begin
			case (n)
				3'h1:    lane_of = 4'h8;
				3'h2:    lane_of = 4'h4;
				3'h3:    lane_of = 4'h2;
				default: lane_of = 4'h1;
			endcase
		end
	endfunction

	function [10:0] bytes_ext;
		input [2:0] n;
		begin
			bytes_ext = {8'h00, n};
		end
	endfunction

	// ----------------------------------------
	// State
	// ----------------------------------------
	reg  [10:0] count_r;
	reg  [10:0] count_nxt;
	reg  [4:0]  sticky_r;
	reg  [3:0]  lanes_r;
	reg  [9:0]  frames_r;
	reg  [9:0]  frames_nxt;
	reg         tag_control_next_r;
	reg         wfr_r;
	reg         timer_en_r;
	reg         frame_mode_enable_r;
	reg  [2:0]  gr_r;
	reg         ipm_r;
	reg         faem_r;
	reg         ufm_r;
	reg         ofm_r;
	reg         txwm_r;
	reg  [15:0] period_r;
	reg  [1:0]  tm_state_r;
	reg  [5:0]  pre_r;
	reg  [15:0] units_r;

	wire [10:0] free_bytes;
	wire        ctl_wr;
	wire        st_wr;
	wire        wr_fits;
	wire        rd_fits;
	wire        sw_rd_fits;
	wire        eof_write;
	wire        frame_ready;
	wire        alarm_cond;
	wire [10:0] gr_bytes;
	wire [4:0]  set_vec;
	wire [4:0]  clr_vec;
	wire [4:0]  mask_vec;
	wire        data_access;
	wire        timer_mode;
	wire        timer_expire;

	assign ctl_wr     = reg_wr && (reg_addr == `TXF_CONTROL_ADDR);
	assign st_wr      = reg_wr && (reg_addr == `TXF_STATUS_ADDR);
	assign free_bytes = `TXF_CAPACITY - count_r;
	assign wr_fits    = bytes_ext(data_wr_bytes) <= free_bytes;
	assign rd_fits    = bytes_ext(mac_rd_bytes) <= count_r;
	assign sw_rd_fits = bytes_ext(data_rd_bytes) <= count_r;

	// ----------------------------------------
	// MAC read handshake
	// ----------------------------------------
	// Short reads are held off with wait states rather than underflowing
	assign mac_rd_grant = mac_rd_req && rd_fits;
	assign mac_rd_wait  = mac_rd_req && !rd_fits;

	// ----------------------------------------
	// Byte count
	// ----------------------------------------
	// Overflowing writes saturate the count; the pointers wrap over unread data
	always @* begin
		count_nxt = count_r;
		if (data_wr) begin
			if (wr_fits)
				count_nxt = count_nxt + bytes_ext(data_wr_bytes);
			else
				count_nxt = `TXF_CAPACITY;
		end
		if (mac_rd_grant)
			count_nxt = count_nxt - bytes_ext(mac_rd_bytes);
		else if (data_rd) begin
			if (sw_rd_fits)
				count_nxt = count_nxt - bytes_ext(data_rd_bytes);
			else
				count_nxt = 11'h000;
		end
	end

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			count_r <= 11'h000;
		else
			count_r <= count_nxt;
	end

	// ----------------------------------------
	// Sticky error flags
	// ----------------------------------------
	assign set_vec[FL_IP]  = ptr_wr && (ptr_wr_value >= `TXF_CAPACITY_WORD);
	assign set_vec[FL_TXW] = mac_rd_wait;
	assign set_vec[FL_FAE] = frame_mode_enable_r && data_wr && retry_hold && !wr_fits;
	assign set_vec[FL_UF]  = data_rd && !mac_rd_grant && !sw_rd_fits;
	assign set_vec[FL_OF]  = data_wr && !wr_fits;

	assign clr_vec[FL_IP]  = st_wr && reg_wdata[`ST_IP_BIT];
	assign clr_vec[FL_TXW] = st_wr && reg_wdata[`ST_TXW_BIT];
	assign clr_vec[FL_FAE] = st_wr && reg_wdata[`ST_FAE_BIT];
	assign clr_vec[FL_UF]  = st_wr && reg_wdata[`ST_UF_BIT];
	assign clr_vec[FL_OF]  = st_wr && reg_wdata[`ST_OF_BIT];

	assign mask_vec[FL_IP]  = ipm_r;
	assign mask_vec[FL_TXW] = txwm_r;
	assign mask_vec[FL_FAE] = faem_r;
	assign mask_vec[FL_UF]  = ufm_r;
	assign mask_vec[FL_OF]  = ofm_r;

	// A new event in the clearing cycle keeps the flag set
	genvar gi;
	generate
		for (gi = 0; gi < 5; gi = gi + 1) begin : g_sticky
			always @(posedge core_clk or negedge rst_n) begin
				if (!rst_n)
					sticky_r[gi] <= 1'b0;
				else if (set_vec[gi])
					sticky_r[gi] <= 1'b1;
				else if (clr_vec[gi])
					sticky_r[gi] <= 1'b0;
			end
		end
	endgenerate

	assign fifo_error_event = |(sticky_r & ~mask_vec);
	assign wait_error       = sticky_r[FL_TXW] && !txwm_r;

	// ----------------------------------------
	// Frame tracking
	// ----------------------------------------
	assign eof_write   = frame_mode_enable_r && data_wr && (wfr_r || data_wr_frame);
	assign frame_ready = frame_mode_enable_r && (frames_r != 10'h000);

	always @* begin
		frames_nxt = frames_r;
		if (eof_write)
			frames_nxt = frames_nxt + 10'h001;
		if (frame_mode_enable_r && mac_rd_grant && mac_rd_frame_end && (frames_nxt != 10'h000))
			frames_nxt = frames_nxt - 10'h001;
		if (!frame_mode_enable_r)
			frames_nxt = 10'h000;
	end

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			frames_r <= 10'h000;
			lanes_r  <= 4'h0;
		end else begin
			frames_r <= frames_nxt;
			if (eof_write)
				lanes_r <= lane_of(data_wr_bytes);
			else if (!frame_mode_enable_r)
				lanes_r <= 4'h0;
		end
	end

	// ----------------------------------------
	// Data write tagging
	// ----------------------------------------
	// Tags are registered so they stand beside the word one cycle after the write
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_tag_control <= 1'b0;
			wr_tag_eof     <= 1'b0;
		end else begin
			wr_tag_control <= data_wr && frame_mode_enable_r && tag_control_next_r;
			wr_tag_eof     <= eof_write;
		end
	end

	// ----------------------------------------
	// Control register
	// ----------------------------------------
	// A control write in the same cycle as a data write wins over the self-clear
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			tag_control_next_r     <= 1'b0;
			wfr_r      <= 1'b0;
			timer_en_r <= 1'b0;
			frame_mode_enable_r    <= 1'b0;
			gr_r       <= `CT_GR_RESET;
			ipm_r      <= 1'b0;
			faem_r     <= 1'b0;
			ufm_r      <= 1'b0;
			ofm_r      <= 1'b0;
			txwm_r     <= `CT_TXWM_RESET;
			period_r   <= 16'h0000;
		end else if (ctl_wr) begin
			tag_control_next_r     <= reg_wdata[`CT_TAG_CONTROL_NEXT_BIT];
			wfr_r      <= reg_wdata[`CT_WFR_BIT];
			timer_en_r <= reg_wdata[`CT_TIMER_BIT];
			frame_mode_enable_r    <= reg_wdata[`CT_FRAME_MODE_ENABLE_BIT];
			gr_r       <= reg_wdata[`CT_GR_HI:`CT_GR_LO];
			ipm_r      <= reg_wdata[`CT_IPM_BIT];
			faem_r     <= reg_wdata[`CT_FAEM_BIT];
			ufm_r      <= reg_wdata[`CT_UFM_BIT];
			ofm_r      <= reg_wdata[`CT_OFM_BIT];
			txwm_r     <= reg_wdata[`CT_TXWM_BIT];
			period_r   <= reg_wdata[`CT_COUNT_HI:`CT_COUNT_LO];
		end else if (data_wr) begin
			tag_control_next_r <= 1'b0;
			wfr_r  <= 1'b0;
		end
	end

	// ----------------------------------------
	// Alarm request
	// ----------------------------------------
	assign alarm_cond = count_r <= {1'b0, alarm_level};
	assign gr_bytes   = {6'h00, gr_r, 2'b00};

	// Set point and clear point differ so the request has hysteresis
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			alarm_request <= 1'b1;
		else if (alarm_cond)
			alarm_request <= 1'b1;
		else if (free_bytes < gr_bytes)
			alarm_request <= 1'b0;
	end

	// ----------------------------------------
	// Service-request timer
	// ----------------------------------------
	assign data_access  = data_wr || data_rd;
	assign timer_mode   = frame_mode_enable_r && timer_en_r;
	assign timer_expire = (tm_state_r == TM_RUN) && (pre_r == `TIMER_PRE_LAST) &&
	                      (units_r + 16'h0001 >= period_r);

	// A zero period keeps the timer from leaving idle, so timer mode entered with zero silences frame requests
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			tm_state_r <= TM_IDLE;
			pre_r      <= 6'h00;
			units_r    <= 16'h0000;
		end else begin
			case (tm_state_r)
				TM_IDLE: begin
					pre_r   <= 6'h00;
					units_r <= 16'h0000;
					if (timer_mode && frame_ready && (period_r != 16'h0000))
						tm_state_r <= TM_RUN;
				end
				TM_RUN: begin
					if (!timer_mode || !frame_ready || data_access) begin
						tm_state_r <= TM_IDLE;
						pre_r      <= 6'h00;
						units_r    <= 16'h0000;
					end else if (timer_expire) begin
						pre_r   <= 6'h00;
						units_r <= 16'h0000;
					end else if (pre_r == `TIMER_PRE_LAST) begin
						pre_r   <= 6'h00;
						units_r <= units_r + 16'h0001;
					end else begin
						pre_r <= pre_r + 6'h01;
					end
				end
				default: begin
					tm_state_r <= TM_IDLE;
					pre_r      <= 6'h00;
					units_r    <= 16'h0000;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Frame request
	// ----------------------------------------
	// Level while frames are held; a one-cycle pulse per period in timer mode
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			frame_request <= 1'b0;
		else if (timer_mode)
			frame_request <= timer_expire && !data_access;
		else
			frame_request <= frame_ready;
	end

	// ----------------------------------------
	// Register read
	// ----------------------------------------
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			reg_rdata <= 32'h00000000;
		else if (reg_rd) begin
			reg_rdata <= 32'h00000000;
			if (reg_addr == `TXF_STATUS_ADDR) begin
				reg_rdata[`ST_IP_BIT]               <= sticky_r[FL_IP];
				reg_rdata[`ST_TXW_BIT]              <= sticky_r[FL_TXW];
				reg_rdata[`ST_LANES_HI:`ST_LANES_LO] <= lanes_r;
				reg_rdata[`ST_FAE_BIT]              <= sticky_r[FL_FAE];
				reg_rdata[`ST_UF_BIT]               <= sticky_r[FL_UF];
				reg_rdata[`ST_OF_BIT]               <= sticky_r[FL_OF];
				reg_rdata[`ST_FRAME_READY_FLAG_BIT]           <= frame_ready;
				reg_rdata[`ST_FULL_BIT]             <= count_r == `TXF_CAPACITY;
				reg_rdata[`ST_ALARM_BIT]            <= alarm_cond;
				reg_rdata[`ST_EMPTY_BIT]            <= count_r == 11'h000;
			end else if (reg_addr == `TXF_CONTROL_ADDR) begin
				reg_rdata[`CT_TAG_CONTROL_NEXT_BIT]             <= tag_control_next_r;
				reg_rdata[`CT_WFR_BIT]              <= wfr_r;
				reg_rdata[`CT_TIMER_BIT]            <= timer_en_r;
				reg_rdata[`CT_FRAME_MODE_ENABLE_BIT]            <= frame_mode_enable_r;
				reg_rdata[`CT_GR_HI:`CT_GR_LO]      <= gr_r;
				reg_rdata[`CT_IPM_BIT]              <= ipm_r;
				reg_rdata[`CT_FAEM_BIT]             <= faem_r;
				reg_rdata[`CT_ONE_BIT]              <= 1'b1;
				reg_rdata[`CT_UFM_BIT]              <= ufm_r;
				reg_rdata[`CT_OFM_BIT]              <= ofm_r;
				reg_rdata[`CT_TXWM_BIT]             <= txwm_r;
				reg_rdata[`CT_COUNT_HI:`CT_COUNT_LO] <= period_r;
			end
		end else
			reg_rdata <= 32'h00000000;
	end

endmodule

/* File: test/tx_fifo_ctrl_assertions.sv */
// Port-level assertions for the transmit FIFO control block
`timescale 1ns/1ps
`include "tx_fifo_regs.vh"
module tx_fifo_ctrl_checker (
	// Clock, reset and register port
	input wire        core_clk,
	input wire        rst_n,
	input wire [15:0] reg_addr,
	input wire        reg_rd,
	input wire [31:0] reg_rdata,
	// Data port and pointer writes
	input wire        data_wr,
	input wire        ptr_wr,
	input wire [31:0] ptr_wr_value,
	input wire        wr_tag_control,
	input wire        wr_tag_eof,
	// Read bus and events
	input wire        mac_rd_req,
	input wire        mac_rd_grant,
	input wire        mac_rd_wait,
	input wire        fifo_error_event,
	input wire        wait_error
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);
	wire st_rd = reg_rd && (reg_addr == `TXF_STATUS_ADDR);

	property p_req_split;
		mac_rd_req |-> (mac_rd_grant != mac_rd_wait);
	endproperty
	a_req_split: assert property (p_req_split) else $error("read request neither granted nor held");
	property p_idle_quiet;
		!mac_rd_req |-> !mac_rd_grant && !mac_rd_wait;
	endproperty
	a_idle_quiet: assert property (p_idle_quiet) else $error("grant or wait without request");
	property p_wait_sticky;
		mac_rd_wait ##1 st_rd |=> reg_rdata[`ST_TXW_BIT];
	endproperty
	a_wait_sticky: assert property (p_wait_sticky) else $error("wait flag not seen after stall");
	property p_wait_err;
		wait_error |-> fifo_error_event;
	endproperty
	a_wait_err: assert property (p_wait_err) else $error("wait error missing from error event");
	property p_ptr_ill;
		ptr_wr && (ptr_wr_value >= `TXF_CAPACITY_WORD) ##2 st_rd |=> reg_rdata[`ST_IP_BIT];
	endproperty
	a_ptr_ill: assert property (p_ptr_ill) else $error("out of range pointer not flagged");
	property p_ctl_tag;
		wr_tag_control |-> $past(data_wr);
	endproperty
	a_ctl_tag: assert property (p_ctl_tag) else $error("control tag without data write");
	property p_eof_tag;
		wr_tag_eof |-> $past(data_wr);
	endproperty
	a_eof_tag: assert property (p_eof_tag) else $error("end tag without data write");
	property p_full_empty;
		st_rd |=> !(reg_rdata[`ST_FULL_BIT] && reg_rdata[`ST_EMPTY_BIT]);
	endproperty
	a_full_empty: assert property (p_full_empty) else $error("full and empty together");
endmodule

bind ethernet_tx_fifo_ctrl tx_fifo_ctrl_checker tx_fifo_ctrl_checker_i (.*);

/* File: test/mac_reader.sv */
// Behavioural MAC transmit reader on the FIFO read bus
`timescale 1ns/1ps
module mac_reader (
	// Clock and reset
	input wire       core_clk,
	input wire       rst_n,
	// Bench command
	input wire       go,
	input wire [2:0] want_bytes,
	// FIFO read bus
	input wire       mac_rd_grant,
	output reg       mac_rd_req,
	output reg [2:0] mac_rd_bytes,
	output reg       mac_rd_frame_end
);
	// Request held until granted; released lines show inverted junk
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			mac_rd_req <= 1'b0;
			mac_rd_bytes <= 3'h0;
			mac_rd_frame_end <= 1'b0;
		end else if (!mac_rd_req && go) begin
			mac_rd_req <= 1'b1;
			mac_rd_bytes <= want_bytes;
			mac_rd_frame_end <= 1'b0;
		end else if (mac_rd_req && mac_rd_grant) begin
			mac_rd_req <= 1'b0;
			mac_rd_bytes <= ~mac_rd_bytes;
			mac_rd_frame_end <= ~mac_rd_frame_end;
		end
	end
endmodule

/* File: test/testbench.sv */
// Self-checking testbench for the transmit FIFO control block
`timescale 1ns/1ps
`include "tx_fifo_regs.vh"
module testbench;
	reg         core_clk = 1'b0;
	reg         rst_n = 1'b0;
	reg  [15:0] reg_addr = 16'h0;
	reg  [31:0] reg_wdata = 32'h0;
	reg         reg_wr = 1'b0;
	reg         reg_rd = 1'b0;
	reg         data_wr = 1'b0;
	reg         data_rd = 1'b0;
	reg  [2:0]  dbytes = 3'h4;
	reg         ptr_wr = 1'b0;
	reg  [31:0] ptr_val = 32'h0;
	reg         go = 1'b0;
	reg         hold = 1'b0;
	wire [31:0] reg_rdata;
	wire        tag_ctl;
	wire        tag_eof;
	wire        req;
	wire [2:0]  rbytes;
	wire        rend;
	wire        grant;
	wire        stall;
	wire        alarm_request;
	wire        frame_request;
	wire        err_ev;
	wire        wait_error;
	integer     err_total = 0;
	integer     total_checks = 0;
	integer     cyc = 0;
	integer     i;
	integer     p1;
	integer     p2;
	reg         got_eof;
	reg         got_ctl;

	always #12.5 core_clk = ~core_clk;

	ethernet_tx_fifo_ctrl ethernet_tx_fifo_ctrl_i (
		.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .data_wr(data_wr),
		.data_wr_bytes(dbytes), .data_wr_frame(1'b0), .data_rd(data_rd), .data_rd_bytes(dbytes),
		.wr_tag_control(tag_ctl), .wr_tag_eof(tag_eof), .ptr_wr(ptr_wr), .ptr_wr_value(ptr_val),
		.alarm_level(10'h010), .retry_hold(hold), .mac_rd_req(req), .mac_rd_bytes(rbytes),
		.mac_rd_frame_end(rend), .mac_rd_grant(grant), .mac_rd_wait(stall),
		.alarm_request(alarm_request), .frame_request(frame_request),
		.fifo_error_event(err_ev), .wait_error(wait_error));

	mac_reader mac_reader_i (.core_clk(core_clk), .rst_n(rst_n), .go(go), .want_bytes(3'h4),
		.mac_rd_grant(grant), .mac_rd_req(req), .mac_rd_bytes(rbytes), .mac_rd_frame_end(rend));

	// ----
	// Bus tasks and compares
	// ----
	task chk(input [31:0] got, input [31:0] exp);
		begin
			total_checks = total_checks + 1;
			if (got !== exp) begin
				err_total = err_total + 1;
				$display("unexpected at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask
	task chk1(input got, input exp);
		begin
			chk({31'h0, got}, {31'h0, exp});
		end
	endtask
	task wr(input [15:0] a, input [31:0] d);
		begin
			@(posedge core_clk);
			reg_addr <= a;
			reg_wdata <= d;
			reg_wr <= 1'b1;
			@(posedge core_clk);
			reg_wr <= 1'b0;
			#1;
		end
	endtask
	task rd(input [15:0] a, input [31:0] exp);
		begin
			@(posedge core_clk);
			reg_addr <= a;
			reg_rd <= 1'b1;
			@(posedge core_clk);
			reg_rd <= 1'b0;
			#1 chk(reg_rdata, exp);
		end
	endtask
	task dp(input w, input [2:0] n);
		begin
			@(posedge core_clk);
			data_wr <= w;
			data_rd <= !w;
			dbytes <= n;
			@(posedge core_clk);
			data_wr <= 1'b0;
			data_rd <= 1'b0;
			#1;
			got_eof = tag_eof;
			got_ctl = tag_ctl;
		end
	endtask
	task ptr(input [31:0] v);
		begin
			@(posedge core_clk);
			ptr_wr <= 1'b1;
			ptr_val <= v;
			@(posedge core_clk);
			ptr_wr <= 1'b0;
		end
	endtask

	// ----
	// Scenarios
	// ----
	task t_reset;
		begin
			rd(`TXF_STATUS_ADDR, 32'h00030000);
			rd(`TXF_CONTROL_ADDR, 32'h01240000);
			rd(16'h91B0, 32'h0);
			$display("reset test done");
		end
	endtask
	task t_wait;
		begin
			@(posedge core_clk);
			go <= 1'b1;
			@(posedge core_clk);
			go <= 1'b0;
			#1 chk1(stall, 1'b1);
			chk1(err_ev, 1'b0);
			rd(`TXF_STATUS_ADDR, 32'h40030000);
			wr(`TXF_CONTROL_ADDR, 32'h01200000);
			chk1(wait_error, 1'b1);
			chk1(err_ev, 1'b1);
			dp(1'b1, 3'h4);
			rd(`TXF_STATUS_ADDR, 32'h40030000);
			chk1(req, 1'b0);
			wr(`TXF_STATUS_ADDR, 32'h40000000);
			chk1(err_ev, 1'b0);
			wr(`TXF_CONTROL_ADDR, 32'h01240000);
			$display("wait test done");
		end
	endtask
	task t_flags;
		begin
			for (i = 0; i < 256; i = i + 1) dp(1'b1, 3'h4);
			rd(`TXF_STATUS_ADDR, 32'h00040000);
			chk1(alarm_request, 1'b0);
			dp(1'b1, 3'h1);
			rd(`TXF_STATUS_ADDR, 32'h00140000);
			chk1(err_ev, 1'b1);
			wr(`TXF_CONTROL_ADDR, 32'h012C0000);
			chk1(err_ev, 1'b0);
			wr(`TXF_STATUS_ADDR, 32'h00100000);
			dp(1'b0, 3'h4);
			rd(`TXF_STATUS_ADDR, 32'h0);
			for (i = 0; i < 250; i = i + 1) dp(1'b0, 3'h4);
			rd(`TXF_STATUS_ADDR, 32'h0);
			dp(1'b0, 3'h4);
			rd(`TXF_STATUS_ADDR, 32'h00020000);
			for (i = 0; i < 4; i = i + 1) dp(1'b0, 3'h4);
			rd(`TXF_STATUS_ADDR, 32'h00030000);
			chk1(alarm_request, 1'b1);
			dp(1'b0, 3'h1);
			rd(`TXF_STATUS_ADDR, 32'h00230000);
			chk1(err_ev, 1'b1);
			wr(`TXF_CONTROL_ADDR, 32'h013C0000);
			chk1(err_ev, 1'b0);
			wr(`TXF_STATUS_ADDR, 32'h00200000);
			wr(`TXF_CONTROL_ADDR, 32'h01240000);
			$display("level test done");
		end
	endtask
	task t_frame;
		begin
			for (i = 1; i < 5; i = i + 1) begin
				wr(`TXF_CONTROL_ADDR, (i == 1) ? 32'h69240000 : 32'h29240000);
				dp(1'b1, i[2:0]);
				chk1(got_eof, 1'b1);
				chk1(got_ctl, i == 1);
				rd(`TXF_STATUS_ADDR, (32'h10000000 >> i) | 32'h000A0000);
				rd(`TXF_CONTROL_ADDR, 32'h09240000);
			end
			wr(`TXF_CONTROL_ADDR, 32'h19240002);
			p1 = -1;
			p2 = -1;
			for (i = 0; i < 400; i = i + 1) begin
				@(posedge core_clk);
				#1;
				if (frame_request === 1'b1 && p1 < 0) p1 = i;
				else if (frame_request === 1'b1 && p2 < 0) p2 = i;
			end
			chk(p2 - p1, 32'h00000080);
			wr(`TXF_CONTROL_ADDR, 32'h01240000);
			rd(`TXF_STATUS_ADDR, 32'h00020000);
			$display("frame test done");
		end
	endtask
	task t_ptr;
		begin
			ptr(32'h000003FF);
			rd(`TXF_STATUS_ADDR, 32'h00020000);
			ptr(32'h00000400);
			rd(`TXF_STATUS_ADDR, 32'h80020000);
			chk1(err_ev, 1'b1);
			wr(`TXF_CONTROL_ADDR, 32'h01A40000);
			chk1(err_ev, 1'b0);
			wr(`TXF_STATUS_ADDR, 32'h80000000);
			rd(`TXF_STATUS_ADDR, 32'h00020000);
			$display("pointer test done");
		end
	endtask
	// Overwrite while a frame is kept for retry, in frame mode
	task t_accept;
		begin
			wr(`TXF_CONTROL_ADDR, 32'h09240000);
			@(posedge core_clk);
			hold <= 1'b1;
			for (i = 0; i < 253; i = i + 1) dp(1'b1, 3'h4);
			rd(`TXF_STATUS_ADDR, 32'h00000000);
			dp(1'b1, 3'h4);
			rd(`TXF_STATUS_ADDR, 32'h00940000);
			wr(`TXF_CONTROL_ADDR, 32'h092C0000);
			chk1(err_ev, 1'b1);
			wr(`TXF_CONTROL_ADDR, 32'h096C0000);
			chk1(err_ev, 1'b0);
			wr(`TXF_STATUS_ADDR, 32'h00900000);
			rd(`TXF_STATUS_ADDR, 32'h00040000);
			@(posedge core_clk);
			hold <= 1'b0;
			$display("accept error test done");
		end
	endtask

	task end_of_test;
		begin
			$display("checks %0d mismatches %0d", total_checks, err_total);
			if (err_total == 0 && total_checks > 0)
				$display("No errors found");
			else
				$display("Errors were found");
			$finish;
		end
	endtask

	always @(posedge core_clk) begin
		cyc = cyc + 1;
		if (cyc == 20000) begin
			err_total = err_total + 1;
			end_of_test;
		end
	end

	initial begin
		repeat (20) @(posedge core_clk);
		rst_n <= 1'b1;
		t_reset;
		t_wait;
		t_flags;
		t_frame;
		t_ptr;
		t_accept;
		end_of_test;
	end
endmodule
